// *** verilog/swd_cfg.svh ***
// constants for the write command block decoder
// What this block does
// - six-byte write: 0Ah, 21-bit address, byte length
// - ten-byte write: 2Ah, address 2-5, length 7-8
// - twelve-byte write: AAh, address 2-5, length 6-9
// - hint bit gives blocks lowest cache priority
// - forced write: commit to media before Good
// - no forced write: Good may precede media
// - zero length seeks only, still Good
// - six-byte write with protection generates guard
// - type 1: reference tag is address low
// - type 2: reference tag is FFFFFFFh
// - owner flag set: application tag FFFFh
// - unformatted media, nonzero check code: illegal
// - code 000b: device generates protection fields
// - code 001b: check guard and reference
// - code 010b: check reference only
// - 011b checks nothing, 100b guard only
// - codes 101b-111b reserved, illegal request
// - failed protection check: aborted, field code
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH
`define SWD_OP_W6        8'h0A
`define SWD_OP_W10       8'h2A
`define SWD_OP_W12       8'hAA
`define SWD_LEN_W6       4'h6
`define SWD_LEN_W10      4'hA
`define SWD_LEN_W12      4'hC
`define SWD_HINT_BIT     4
`define SWD_FORCE_BIT    3
`define SWD_PTYPE_1      3'h0
`define SWD_PTYPE_2      3'h1
`define SWD_REF_TYPE2    32'h0FFFFFFF
`define SWD_APP_OWNED    16'hFFFF
`define SWD_APP_FREE     16'h0000
`define SWD_CHK_NONE_TX  3'h0
`define SWD_CHK_ALL      3'h1
`define SWD_CHK_REF      3'h2
`define SWD_CHK_OFF      3'h3
`define SWD_CHK_GUARD    3'h4
`define SWD_SK_GOOD      4'h0
`define SWD_SK_ILLEGAL   4'h5
`define SWD_SK_ABORTED   4'hB
`define SWD_ASC_NONE     8'h00
`define SWD_ASC_BAD_OP   8'h20
`define SWD_ASC_BAD_FLD  8'h24
`define SWD_ASC_PI       8'h10
`define SWD_ASCQ_NONE    8'h00
`define SWD_ASCQ_GUARD   8'h01
`define SWD_ASCQ_APP     8'h02
`define SWD_ASCQ_REF     8'h03
`define SWD_ADDR_CTRL    8'h00
`define SWD_ADDR_STAT    8'h04
`define SWD_ADDR_LBA     8'h08
`define SWD_ADDR_LEN     8'h0C
`define SWD_CTRL_PIEN    0
`define SWD_CTRL_PT_LO   1
`define SWD_CTRL_PT_HI   3
`define SWD_CTRL_ATO     4
`define SWD_CTRL_RESET   32'h00000000
`endif

// *** verilog/swd_pkg.sv ***
// types shared by the write command block decoder
`default_nettype none
package swd_pkg;
  // one byte of a command block from the initiator
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } swd_cdb_byte_t;

  // decoded command handed to the media and cache path
  typedef struct packed {
    logic [31:0] lba;
    logic [31:0] blocks;
    logic        low_retention;
    logic        forced_write;
    logic        gen_pi;
    logic        ref_incr;
    logic [31:0] ref_tag;
    logic [15:0] app_tag;
    logic        chk_guard;
    logic        chk_ref;
    logic        chk_app;
  } swd_cmd_t;

  // completion report from the media and cache path
  typedef struct packed {
    logic xfer_done;
    logic committed;
    logic guard_err;
    logic ref_err;
    logic app_err;
  } swd_media_t;

  // final status toward the initiator
  typedef struct packed {
    logic       valid;
    logic       check_cond;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } swd_status_t;

  typedef enum logic [2:0] {
    SWD_IDLE, SWD_COLLECT, SWD_DECODE, SWD_ISSUE, SWD_WAIT_XFER, SWD_WAIT_COMMIT, SWD_REPORT
  } swd_state_t;
endpackage : swd_pkg
`default_nettype wire

// *** verilog/swd_decoder.sv ***
// write command block decoder with protection mode selection and sense reporting
`include "swd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module swd_decoder
(
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire swd_pkg::swd_cdb_byte_t i_cdb,
  output var  logic                 o_cdb_ready,
  output var  logic                 o_cmd_valid,
  output var  swd_pkg::swd_cmd_t    o_cmd,
  input  wire logic                 i_cmd_ready,
  input  wire swd_pkg::swd_media_t  i_media,
  output var  swd_pkg::swd_status_t o_status,
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output var  logic [31:0]          o_rdata
);
  import swd_pkg::*;

  swd_state_t  state_reg;
  logic [7:0]  cdb_reg [0:11];
  logic [3:0]  count_reg;
  logic [3:0]  need_reg;
  logic [31:0] ctrl_reg;
  swd_cmd_t    cmd_next;
  swd_status_t fail_next;
  logic        fail_hit;
  logic [2:0]  chk_code;
  logic        pi_format_enabled;
  logic [2:0]  pi_type;
  logic        app_tag_owner_flag;
  logic [7:0]  opcode;

  assign pi_format_enabled  = ctrl_reg[`SWD_CTRL_PIEN];
  assign pi_type            = ctrl_reg[`SWD_CTRL_PT_HI:`SWD_CTRL_PT_LO];
  assign app_tag_owner_flag = ctrl_reg[`SWD_CTRL_ATO];
  assign opcode             = cdb_reg[0];

  // software control word: protection format and tag ownership
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl_reg <= `SWD_CTRL_RESET;
    else if (i_wr && i_addr == `SWD_ADDR_CTRL)
      ctrl_reg <= i_wdata;
  end

  // read port: data stand in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 32'h00000000;
    else if (i_rd)
    begin
      if (i_addr == `SWD_ADDR_CTRL)
        o_rdata <= ctrl_reg;
      else if (i_addr == `SWD_ADDR_STAT)
        o_rdata <= {5'h00, state_reg, o_status.ascq, o_status.asc, 3'h0, o_status.check_cond, o_status.sense_key};
      else if (i_addr == `SWD_ADDR_LBA)
        o_rdata <= o_cmd.lba;
      else if (i_addr == `SWD_ADDR_LEN)
        o_rdata <= o_cmd.blocks;
      else
        o_rdata <= 32'h00000000;
    end
  end

  // combinational decode of the collected block
  always_comb
  begin
    cmd_next  = '0;
    fail_next = '0;
    fail_hit  = 1'b0;
    chk_code  = cdb_reg[1][7:5];
    if (opcode == `SWD_OP_W6)
    begin
      chk_code       = `SWD_CHK_NONE_TX;
      cmd_next.lba    = {11'h000, cdb_reg[1][4:0], cdb_reg[2], cdb_reg[3]};
      cmd_next.blocks = {24'h000000, cdb_reg[4]};
    end
    else if (opcode == `SWD_OP_W10)
    begin
      cmd_next.lba    = {cdb_reg[2], cdb_reg[3], cdb_reg[4], cdb_reg[5]};
      cmd_next.blocks = {16'h0000, cdb_reg[7], cdb_reg[8]};
    end
    else
    begin
      cmd_next.lba    = {cdb_reg[2], cdb_reg[3], cdb_reg[4], cdb_reg[5]};
      cmd_next.blocks = {cdb_reg[6], cdb_reg[7], cdb_reg[8], cdb_reg[9]};
    end
    // the six-byte form has no flag bits; its byte 1 holds address bits
    if (opcode != `SWD_OP_W6)
    begin
      cmd_next.low_retention = cdb_reg[1][`SWD_HINT_BIT];
      cmd_next.forced_write  = cdb_reg[1][`SWD_FORCE_BIT];
    end
    // protection handling by check code; application tag checks only exist on 32-byte writes
    cmd_next.chk_app = 1'b0;
    if (chk_code == `SWD_CHK_NONE_TX)
      cmd_next.gen_pi = pi_format_enabled;
    else if (chk_code == `SWD_CHK_ALL)
    begin
      cmd_next.chk_guard = 1'b1;
      cmd_next.chk_ref   = 1'b1;
    end
    else if (chk_code == `SWD_CHK_REF)
      cmd_next.chk_ref = 1'b1;
    else if (chk_code == `SWD_CHK_GUARD)
      cmd_next.chk_guard = 1'b1;
    // code 011b leaves every check off
    if (pi_type == `SWD_PTYPE_2)
      cmd_next.ref_tag = `SWD_REF_TYPE2;
    else
    begin
      cmd_next.ref_tag  = cmd_next.lba;
      cmd_next.ref_incr = 1'b1;
    end
    cmd_next.app_tag = app_tag_owner_flag ? `SWD_APP_OWNED : `SWD_APP_FREE;
    // illegal field cases: unformatted media with nonzero code, or a reserved code
    if ((!pi_format_enabled && chk_code != `SWD_CHK_NONE_TX) || chk_code > `SWD_CHK_GUARD)
    begin
      fail_hit             = 1'b1;
      fail_next.check_cond = 1'b1;
      fail_next.sense_key  = `SWD_SK_ILLEGAL;
      fail_next.asc        = `SWD_ASC_BAD_FLD;
    end
  end

  // byte count expected for the opcode in the first byte
  function automatic logic [3:0] swd_cdb_len(input logic [7:0] op);
    if (op == `SWD_OP_W6)
      swd_cdb_len = `SWD_LEN_W6;
    else if (op == `SWD_OP_W10)
      swd_cdb_len = `SWD_LEN_W10;
    else if (op == `SWD_OP_W12)
      swd_cdb_len = `SWD_LEN_W12;
    else
      swd_cdb_len = 4'h1;
  endfunction : swd_cdb_len

  // command byte capture; extra bytes are refused by dropping ready
  always_ff @(posedge i_clk)
  begin
    if (o_cdb_ready && i_cdb.valid)
      cdb_reg[count_reg] <= i_cdb.data;
  end

  // sequencer: collect, decode, hand to media path, wait, report
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg   <= SWD_IDLE;
      count_reg   <= 4'h0;
      need_reg    <= 4'h1;
      o_cdb_ready <= 1'b1;
      o_cmd_valid <= 1'b0;
      o_cmd       <= '0;
      o_status    <= '0;
    end
    else
    begin
      o_status.valid <= 1'b0;
      case (state_reg)
        SWD_IDLE:
        begin
          if (i_cdb.valid)
          begin
            need_reg  <= swd_cdb_len(i_cdb.data);
            count_reg <= 4'h1;
            if (swd_cdb_len(i_cdb.data) == 4'h1)
            begin
              o_cdb_ready <= 1'b0;
              state_reg   <= SWD_DECODE;
            end
            else
              state_reg <= SWD_COLLECT;
          end
        end
        SWD_COLLECT:
        begin
          if (i_cdb.valid)
          begin
            count_reg <= count_reg + 4'h1;
            if (count_reg + 4'h1 == need_reg)
            begin
              o_cdb_ready <= 1'b0;
              state_reg   <= SWD_DECODE;
            end
          end
        end
        SWD_DECODE:
        begin
          o_status <= '0;
          if (need_reg == 4'h1)
          begin
            // unknown opcode: not a write this block handles
            o_status.check_cond <= 1'b1;
            o_status.sense_key  <= `SWD_SK_ILLEGAL;
            o_status.asc        <= `SWD_ASC_BAD_OP;
            state_reg           <= SWD_REPORT;
          end
          else if (fail_hit)
          begin
            o_status  <= fail_next;
            state_reg <= SWD_REPORT;
          end
          else
          begin
            // zero length still issues so the seek happens
            o_cmd       <= cmd_next;
            o_cmd_valid <= 1'b1;
            state_reg   <= SWD_ISSUE;
          end
        end
        SWD_ISSUE:
        begin
          if (i_cmd_ready)
          begin
            o_cmd_valid <= 1'b0;
            state_reg   <= SWD_WAIT_XFER;
          end
        end
        SWD_WAIT_XFER:
        begin
          if (i_media.xfer_done)
          begin
            if (i_media.guard_err || i_media.ref_err || i_media.app_err)
            begin
              o_status.check_cond <= 1'b1;
              o_status.sense_key  <= `SWD_SK_ABORTED;
              o_status.asc        <= `SWD_ASC_PI;
              if (i_media.guard_err)
                o_status.ascq <= `SWD_ASCQ_GUARD;
              else if (i_media.app_err)
                o_status.ascq <= `SWD_ASCQ_APP;
              else
                o_status.ascq <= `SWD_ASCQ_REF;
              state_reg <= SWD_REPORT;
            end
            else if (o_cmd.forced_write && !i_media.committed)
              state_reg <= SWD_WAIT_COMMIT;
            else
              state_reg <= SWD_REPORT;
          end
        end
        SWD_WAIT_COMMIT:
        begin
          // good status held back until the media owns the data
          if (i_media.committed)
            state_reg <= SWD_REPORT;
        end
        SWD_REPORT:
        begin
          o_status.valid <= 1'b1;
          o_cdb_ready    <= 1'b1;
          count_reg      <= 4'h0;
          state_reg      <= SWD_IDLE;
        end
        default:
          state_reg <= SWD_IDLE;
      endcase
    end
  end
endmodule : swd_decoder
`default_nettype wire

// *** tb/swd_props.sv ***
// assertion checker for the write command decoder
`timescale 1ns/1ps
`default_nettype none
module swd_props
(
  input wire logic                 i_clk,
  input wire logic                 i_reset,
  input wire logic                 o_cdb_ready,
  input wire logic                 o_cmd_valid,
  input wire swd_pkg::swd_cmd_t    o_cmd,
  input wire logic                 i_cmd_ready,
  input wire swd_pkg::swd_media_t  i_media,
  input wire swd_pkg::swd_status_t o_status
);
  import swd_pkg::*;
  logic pend_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // a forced write stays pending until the media reports the commit
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      pend_reg <= 1'b0;
    else if (o_cmd_valid && i_cmd_ready)
      pend_reg <= o_cmd.forced_write;
    else if (i_media.committed)
      pend_reg <= 1'b0;
  sequence s_accept; o_cmd_valid && i_cmd_ready; endsequence
  sequence s_good; o_status.valid && !o_status.check_cond; endsequence
  property p_hold; o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd); endproperty
  a_hold: assert property (p_hold) else $error("command changed before accept");
  property p_busy; o_cmd_valid |-> !o_cdb_ready; endproperty
  a_busy: assert property (p_busy) else $error("bytes taken while command pending");
  property p_forced; s_good |-> !pend_reg; endproperty
  a_forced: assert property (p_forced) else $error("good status before commit");
  property p_done; s_accept |-> ##[2:40] o_status.valid; endproperty
  a_done: assert property (p_done) else $error("no status after accept");
  property p_pulse; o_status.valid |=> !o_status.valid && o_cdb_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("status not a single pulse");
  property p_good; s_good |-> o_status.sense_key == 4'h0 && o_status.asc == 8'h00; endproperty
  a_good: assert property (p_good) else $error("good status with sense");
  property p_abort; o_status.valid && o_status.sense_key == 4'hB |-> o_status.check_cond &&
    o_status.asc == 8'h10 && o_status.ascq inside {8'h01, 8'h02, 8'h03}; endproperty
  a_abort: assert property (p_abort) else $error("bad aborted sense");
  property p_illegal; o_status.valid && o_status.sense_key == 4'h5 |-> o_status.check_cond &&
    o_status.asc inside {8'h20, 8'h24}; endproperty
  a_illegal: assert property (p_illegal) else $error("bad illegal request sense");
  property p_app; o_cmd_valid |-> !o_cmd.chk_app; endproperty
  a_app: assert property (p_app) else $error("application tag check enabled");
endmodule : swd_props
bind swd_decoder swd_props u_props (.i_clk(i_clk), .i_reset(i_reset), .o_cdb_ready(o_cdb_ready),
  .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .i_cmd_ready(i_cmd_ready), .i_media(i_media), .o_status(o_status));
`default_nettype wire

// *** tb/swd_media_model.sv ***
// media and cache path model answering decoded write commands
`timescale 1ns/1ps
`default_nettype none
module swd_media_model
(
  input  wire logic           i_clk,
  input  wire logic           i_reset,
  input  wire logic           i_valid,
  input  wire logic [3:0]     i_delay,
  input  wire logic           i_late,
  input  wire logic           i_gerr,
  input  wire logic           i_rerr,
  output var  logic           o_ready,
  output var  swd_pkg::swd_media_t o_media
);
  import swd_pkg::*;
  logic [4:0] cnt_reg;
  // accept once, report after the delay; a late commit trails by three cycles
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      cnt_reg <= 5'h00;
      o_ready <= 1'b0;
      o_media <= '0;
    end
    else
    begin
      o_ready <= i_valid && cnt_reg == 5'h00 && !o_ready;
      o_media <= '0;
      if (o_ready || cnt_reg != 5'h00)
        cnt_reg <= cnt_reg + 5'h01;
      if (cnt_reg == {1'b0, i_delay})
        o_media <= '{xfer_done: 1'b1, committed: !i_late, guard_err: i_gerr, ref_err: i_rerr, app_err: 1'b0};
      if (cnt_reg == {1'b0, i_delay} + 5'h03)
      begin
        o_media.committed <= i_late;
        cnt_reg <= 5'h00;
      end
    end
endmodule : swd_media_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the write command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swd_pkg::*;
  logic clk, rst, wr, rd, late, gerr, rerr, rdy, cv, cr;
  logic [7:0] addr, op;
  logic [31:0] wdata, rdata, seed, lba, len, v;
  logic [3:0] dly;
  logic [7:0] b [12];
  swd_cdb_byte_t cdb;
  swd_cmd_t cmd;
  swd_media_t med;
  swd_status_t st;
  integer err_total, total_checks, n, k;
  swd_decoder DUT (.i_clk(clk), .i_reset(rst), .i_cdb(cdb), .o_cdb_ready(cr), .o_cmd_valid(cv), .o_cmd(cmd),
    .i_cmd_ready(rdy), .i_media(med), .o_status(st), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata));
  swd_media_model u_media (.i_clk(clk), .i_reset(rst), .i_valid(cv), .i_delay(dly), .i_late(late),
    .i_gerr(gerr), .i_rerr(rerr), .o_ready(rdy), .o_media(med));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic reg_acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : reg_acc
  // guard and reference checks chosen by the check code
  function automatic logic [1:0] f_chk(input logic [7:0] o, input logic [2:0] c);
    if (o == 8'h0A)
      return 2'b00;
    return {c == 3'h1 || c == 3'h4, c == 3'h1 || c == 3'h2};
  endfunction : f_chk
  function automatic logic f_bad(input logic [7:0] o, input logic [2:0] c, input logic pien);
    return o != 8'h0A && (c > 3'h4 || (c != 3'h0 && !pien));
  endfunction : f_bad
  task automatic run_cmd(input logic [4:0] ctl, input logic [2:0] code);
    logic hint, forced_media_write, bad, known, seen;
    logic [1:0] ck;
    logic [21:0] es;
    integer nb;
    reg_acc(8'h00, {27'h0, ctl}, 1'b1);
    v = $random(seed);
    lba = $random(seed);
    len = $random(seed);
    known = op inside {8'h0A, 8'h2A, 8'hAA};
    {hint, forced_media_write} = (op == 8'h0A) ? 2'b00 : v[7:6];
    if (op == 8'h0A)
      code = 3'h0;
    ck = f_chk(op, code);
    bad = f_bad(op, code, ctl[0]);
    b = '{default: 8'h00};
    b[0] = op;
    b[1] = {code, hint, forced_media_write, 3'h0};
    {b[2], b[3], b[4], b[5]} = lba;
    nb = (op == 8'h0A) ? 6 : (op == 8'h2A) ? 10 : (op == 8'hAA) ? 12 : 1;
    if (op == 8'h0A)
    begin
      lba = {11'h0, lba[20:0]};
      len = {24'h0, len[7:1], 1'b1};
      {b[1], b[2], b[3], b[4]} = {lba[23:0], len[7:0]};
    end
    else if (op == 8'h2A)
    begin
      len = v[9:8] == 2'b00 ? 32'h0 : {16'h0, len[15:0]};
      {b[7], b[8]} = len[15:0];
    end
    else
      {b[6], b[7], b[8], b[9]} = len;
    dly <= {1'b0, v[2:0]} + 4'h2;
    late <= v[3];
    gerr <= v[4] & ck[1];
    rerr <= v[5] & ck[0];
    es = !known ? 22'h352000 : bad ? 22'h352400 : (v[4] & ck[1]) ? 22'h3B1001 :
      (v[5] & ck[0]) ? 22'h3B1003 : 22'h200000;
    for (k = 0; k < nb; k++)
    begin
      @(posedge clk);
      cdb <= {1'b1, b[k]};
    end
    @(posedge clk);
    cdb <= '0;
    seen = 1'b0;
    for (k = 0; k < 80 && st.valid !== 1'b1; k++)
    begin
      @(negedge clk);
      if (cv === 1'b1 && !seen)
      begin
        seen = 1'b1;
        chk({cmd.lba, cmd.blocks}, {lba, len});
        chk({cmd.low_retention, cmd.forced_write}, {hint, forced_media_write});
        chk({cmd.chk_guard, cmd.chk_ref, cmd.gen_pi}, {ck, ctl[0] && code == 3'h0});
        if (op == 8'h0A && ctl[0])
          chk({cmd.ref_tag, cmd.app_tag, cmd.ref_incr},
            {ctl[3:1] == 3'h1 ? 32'h0FFFFFFF : lba, {16{ctl[4]}}, ctl[3:1] != 3'h1});
      end
    end
    chk(seen, known && !bad);
    // byte port must be open again in the same cycle as the status pulse
    chk({st, cr}, {es, 1'b1});
    reg_acc(8'h04, 32'h0, 1'b0);
    chk({v[23:8], v[4:0]}, {es[7:0], es[15:8], es[20:16]});
    // the last issued command stays readable until the next one is issued
    if (known && !bad)
    begin
      reg_acc(8'h08, 32'h0, 1'b0);
      chk(v, lba);
      reg_acc(8'h0C, 32'h0, 1'b0);
      chk(v, len);
    end
  endtask : run_cmd
  initial
  begin
    seed = 32'h44ee;
    err_total = 0;
    total_checks = 0;
    {rst, cdb, addr, wdata, wr, rd, late, gerr, rerr} = {1'b1, 9'h0, 8'h00, 32'h0, 5'h00};
    dly = 4'h2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    reg_acc(8'h00, 32'h0, 1'b0);
    chk(v, 32'h0);
    reg_acc(8'h00, 32'h0000001F, 1'b1);
    reg_acc(8'h00, 32'h0, 1'b0);
    chk(v, 32'h0000001F);
    reg_acc(8'hFC, 32'h0, 1'b0);
    chk(v, 32'h0);
    op = 8'h28;
    run_cmd(5'h01, 3'h0);
    for (n = 0; n < 60; n++)
    begin
      op = (n % 3 == 0) ? 8'h0A : (n % 3 == 1) ? 8'h2A : 8'hAA;
      v = $random(seed);
      run_cmd(v[4:0], n < 16 ? n[3:1] : v[7:5]);
    end
    report_and_stop();
  end
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
